/* File: hdl/intr_pkg.sv */
// shared constants, register map and carrier types of the interrupt and event transfer block
package intr_pkg;
  // ==========================================================================
  // sizes
  localparam int N_NODE = 96;
  localparam int N_CH   = 8;
  localparam int N_SH   = 4;
  localparam int N_HW   = 6;
  localparam int N_TRAP = N_HW + 2;
  localparam int N_RTR  = 4;
  localparam int PW     = 4;
  localparam int AW     = 24;
  localparam int CW     = 16;
  // ==========================================================================
  // register byte offsets
  localparam logic [11:0] NODE_BASE = 12'h000;
  localparam logic [11:0] SRC_SEL   = 12'h180;
  localparam logic [11:0] TRAP_FLAG = 12'h184;
  localparam logic [11:0] PIN_CFG   = 12'h188;
  localparam logic [11:0] RTR_EDGE  = 12'h18c;
  localparam logic [11:0] RTR_ROUTE = 12'h190;
  localparam logic [11:0] RTR_PAT   = 12'h194;
  localparam logic [11:0] STATUS    = 12'h198;
  localparam logic [11:0] CH_BASE   = 12'h200;
  // ==========================================================================
  // field positions
  localparam int N_EN_BIT    = 6;
  localparam int N_REQ_BIT   = 7;
  localparam int N_ROUTE_BIT = 8;
  localparam int N_CH_LSB    = 9;
  localparam int C_WORD      = 0;
  localparam int C_INC_SRC   = 1;
  localparam int C_INC_DST   = 2;
  localparam int C_CONT      = 3;
  localparam int RTR_MISS_LSB = 16;
  // ==========================================================================
  // timing counts and vectors
  localparam logic [3:0] RESP_JC  = 4'h7;
  localparam logic [3:0] RESP_NJC = 4'hb;
  localparam logic [7:0] TRAP_VEC_BASE = 8'h00;
  localparam logic [7:0] NODE_VEC_BASE = 8'h20;
  // ==========================================================================
  // types
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_WAIT = 2'b10} arb_state_e;
  typedef struct packed {
    logic       valid;
    logic       trap;
    logic [7:0] vec;
  } branch_s;
  typedef struct packed {
    logic          valid;
    logic          word;
    logic [2:0]    ch;
    logic [AW-1:0] src;
    logic [AW-1:0] dst;
  } xfer_s;
endpackage

/* File: hdl/interrupt_and_event_transfer.sv */
// interrupt arbiter, event transfer channels, request router and trap unit
`timescale 1ns/1ps
module interrupt_and_event_transfer #(
  parameter int N_NODE = intr_pkg::N_NODE,
  parameter int N_CH   = intr_pkg::N_CH
) (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire logic                        ce,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // request sources
  input  wire logic [N_NODE-intr_pkg::N_SH-1:0] periph_req,
  input  wire logic [intr_pkg::N_SH-1:0]   shared_src,
  input  wire logic [intr_pkg::N_RTR-1:0]  rtr_in,
  input  wire logic [intr_pkg::N_HW-1:0]   hw_trap,
  input  wire logic [2:0]                  svc_pin,
  // cpu side
  input  wire logic [intr_pkg::PW-1:0]     cpu_level,
  input  wire logic                        jump_cache,
  input  wire logic                        trap_done,
  input  wire logic                        sw_trap_valid,
  input  wire logic [7:0]                  sw_trap_num,
  output intr_pkg::branch_s                branch,
  output intr_pkg::xfer_s                  xfer
);
  localparam int SH_BASE = N_NODE - intr_pkg::N_SH;
  localparam int PW = intr_pkg::PW;
  localparam int AW = intr_pkg::AW;
  localparam int CW = intr_pkg::CW;
  localparam int NT = intr_pkg::N_TRAP;

  generate
    if (N_NODE > 96 || N_NODE < intr_pkg::N_SH + 1 || N_CH < 1 || N_CH > 8) begin : g_bad
      $error("unsupported node or channel count");
    end
  endgenerate

  // ==========================================================================
  // address decode helpers
  function automatic logic in_nodes(input logic [11:0] a);
    return a < intr_pkg::SRC_SEL;
  endfunction
  function automatic logic in_chs(input logic [11:0] a);
    return a[11:7] == intr_pkg::CH_BASE[11:7];
  endfunction

  // ==========================================================================
  // state
  logic [PW-1:0]  prio_q  [N_NODE];
  logic [2:0]     chsel_q [N_NODE];
  logic [N_NODE-1:0] en_q, req_q, route_q, force_std_q;
  logic [AW-1:0]  ch_src_q [N_CH];
  logic [AW-1:0]  ch_dst_q [N_CH];
  logic [CW-1:0]  ch_cnt_q [N_CH];
  logic [3:0]     ch_ctl_q [N_CH];
  logic [11:0]    src_sel_q;
  logic [NT-1:0]  trap_flag_q, trap_pend_q;
  logic [2:0]     svc_map_q, svc_prev_q;
  logic [7:0]     rtr_edge_q;
  logic [15:0]    rtr_route_q;
  logic [19:0]    rtr_pat_q;
  logic [3:0]     rtr_prev_q;
  logic           trap_busy_q;
  logic [2:0]     trap_lvl_q;
  intr_pkg::arb_state_e state_q;
  logic [3:0]     cnt_q;
  logic [6:0]     svc_q;
  logic           pready_q, pslverr_q;
  logic [31:0]    prdata_q;
  intr_pkg::branch_s branch_q;
  intr_pkg::xfer_s   xfer_q;

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign branch  = branch_q;
  assign xfer    = xfer_q;

  // ==========================================================================
  // apb access
  logic        wr, node_we, ch_we;
  logic [6:0]  nidx;
  logic [2:0]  cidx;
  logic [31:0] rd;
  logic        hit;
  assign nidx    = paddr[8:2];
  assign cidx    = paddr[6:4];
  assign wr      = psel & penable & pwrite & pready_q;
  assign node_we = wr && in_nodes(paddr) && int'(nidx) < N_NODE;
  assign ch_we   = wr && in_chs(paddr) && int'(cidx) < N_CH;

  always_comb begin
    rd  = '0;
    hit = 1'b1;
    if (in_nodes(paddr) && int'(nidx) < N_NODE) begin
      rd[PW-1:0] = prio_q[nidx];
      rd[intr_pkg::N_EN_BIT] = en_q[nidx];
      rd[intr_pkg::N_REQ_BIT] = req_q[nidx];
      rd[intr_pkg::N_ROUTE_BIT] = route_q[nidx];
      rd[intr_pkg::N_CH_LSB +: 3] = chsel_q[nidx];
    end else if (in_chs(paddr) && int'(cidx) < N_CH) begin
      case (paddr[3:2])
        2'h0:    rd[AW-1:0] = ch_src_q[cidx];
        2'h1:    rd[AW-1:0] = ch_dst_q[cidx];
        2'h2:    rd[CW-1:0] = ch_cnt_q[cidx];
        default: rd[3:0] = ch_ctl_q[cidx];
      endcase
    end else begin
      case (paddr)
        intr_pkg::SRC_SEL:   rd[11:0] = src_sel_q;
        intr_pkg::TRAP_FLAG: rd[NT-1:0] = trap_flag_q;
        intr_pkg::PIN_CFG:   rd[2:0] = svc_map_q;
        intr_pkg::RTR_EDGE:  rd[7:0] = rtr_edge_q;
        intr_pkg::RTR_ROUTE: rd[15:0] = rtr_route_q;
        intr_pkg::RTR_PAT:   rd[19:0] = rtr_pat_q;
        intr_pkg::STATUS:    rd[6:0] = {trap_lvl_q, trap_busy_q, cnt_q == 4'h0, state_q};
        default:             hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else if (ce) begin
      if (psel && !penable && !pready_q) begin
        pready_q  <= 1'b1;
        pslverr_q <= !hit;
        prdata_q  <= rd;
      end else begin
        pready_q  <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // external request router and service pins
  logic [3:0] rtr_evt, rtr_out;
  logic [2:0] svc_rise;
  logic       system_request_zero, system_request_one;
  logic [NT-1:0] tev;
  genvar g;
  generate
    for (g = 0; g < intr_pkg::N_RTR; g++) begin : g_rtr
      logic [3:0] m;
      logic       match;
      assign rtr_evt[g] = (rtr_in[g] & ~rtr_prev_q[g] & rtr_edge_q[2*g])
                        | (~rtr_in[g] & rtr_prev_q[g] & rtr_edge_q[2*g+1]);
      assign m = rtr_route_q[4*g +: 4];
      assign match = (rtr_in & m) == (rtr_pat_q[4*g +: 4] & m);
      assign rtr_out[g] = |(rtr_evt & m)
                        & (rtr_pat_q[intr_pkg::RTR_MISS_LSB+g] ? !match : match);
    end
  endgenerate
  assign svc_rise = svc_pin & ~svc_prev_q;
  assign system_request_zero = |(svc_rise & ~svc_map_q);
  assign system_request_one  = |(svc_rise & svc_map_q);
  assign tev = {system_request_one, system_request_zero, hw_trap};

  // ==========================================================================
  // node sources
  logic [N_NODE-1:0] src_evt, set_evt;
  logic [7:0]        sh_pool;
  assign sh_pool = {rtr_out, shared_src};
  generate
    for (g = 0; g < N_NODE; g++) begin : g_src
      if (g < SH_BASE) begin : g_ded
        assign src_evt[g] = periph_req[g];
      end else begin : g_shr
        assign src_evt[g] = sh_pool[src_sel_q[3*(g-SH_BASE) +: 3]];
      end
    end
  endgenerate

  // ==========================================================================
  // arbitration
  logic          found, grant, xfer_go, std_go, sw_go, take_trap, tany, reach_zero, cont;
  logic [6:0]    best;
  logic [PW-1:0] best_prio;
  logic [2:0]    tidx, xch;
  logic [CW-1:0] xcnt;
  logic [3:0]    resp;

  always_comb begin
    found = 1'b0;
    best = '0;
    best_prio = '0;
    for (int n = 0; n < N_NODE; n++) begin
      if (req_q[n] && en_q[n] && (!found || prio_q[n] > best_prio)) begin
        found = 1'b1;
        best = 7'(n);
        best_prio = prio_q[n];
      end
    end
    tany = 1'b0;
    tidx = '0;
    for (int t = NT - 1; t >= 0; t--) begin
      if (trap_pend_q[t]) begin
        tany = 1'b1;
        tidx = 3'(t);
      end
    end
  end

  assign xch  = chsel_q[best];
  assign xcnt = ch_cnt_q[xch];
  assign cont = ch_ctl_q[xch][intr_pkg::C_CONT];
  assign take_trap = tany && (!trap_busy_q || tidx < trap_lvl_q);
  assign sw_go = sw_trap_valid && !take_trap && state_q == intr_pkg::ST_IDLE;
  assign grant = found && best_prio > cpu_level && !trap_busy_q && !take_trap && !sw_go
               && state_q == intr_pkg::ST_IDLE;
  assign xfer_go = grant && route_q[best] && !force_std_q[best] && (cont || xcnt != '0);
  assign std_go = grant && !xfer_go;
  assign reach_zero = xfer_go && !cont && xcnt == CW'(1);
  assign resp = jump_cache ? intr_pkg::RESP_JC : intr_pkg::RESP_NJC;

  always_comb begin
    for (int n = 0; n < N_NODE; n++) begin
      set_evt[n] = src_evt[n]
                 | (reach_zero && best == 7'(n))
                 | (take_trap && state_q == intr_pkg::ST_WAIT && svc_q == 7'(n));
    end
  end

  // ==========================================================================
  // node registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int n = 0; n < N_NODE; n++) begin
        prio_q[n]  <= '0;
        chsel_q[n] <= '0;
      end
      en_q        <= '0;
      req_q       <= '0;
      route_q     <= '0;
      force_std_q <= '0;
    end else if (ce) begin
      for (int n = 0; n < N_NODE; n++) begin
        if (node_we && nidx == 7'(n)) begin
          prio_q[n]  <= pwdata[PW-1:0];
          en_q[n]    <= pwdata[intr_pkg::N_EN_BIT];
          req_q[n]   <= pwdata[intr_pkg::N_REQ_BIT];
          route_q[n] <= pwdata[intr_pkg::N_ROUTE_BIT];
          chsel_q[n] <= pwdata[intr_pkg::N_CH_LSB +: 3];
        end
        if ((std_go || xfer_go) && best == 7'(n)) begin
          req_q[n] <= 1'b0;
        end
        if (std_go && best == 7'(n)) begin
          force_std_q[n] <= 1'b0;
        end
        if (set_evt[n]) begin
          req_q[n] <= 1'b1;
        end
        if (reach_zero && best == 7'(n)) begin
          force_std_q[n] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // transfer channels
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int c = 0; c < N_CH; c++) begin
        ch_src_q[c] <= '0;
        ch_dst_q[c] <= '0;
        ch_cnt_q[c] <= '0;
        ch_ctl_q[c] <= '0;
      end
      xfer_q <= '0;
    end else if (ce) begin
      for (int c = 0; c < N_CH; c++) begin
        if (ch_we && cidx == 3'(c)) begin
          case (paddr[3:2])
            2'h0:    ch_src_q[c] <= pwdata[AW-1:0];
            2'h1:    ch_dst_q[c] <= pwdata[AW-1:0];
            2'h2:    ch_cnt_q[c] <= pwdata[CW-1:0];
            default: ch_ctl_q[c] <= pwdata[3:0];
          endcase
        end
        if (xfer_go && xch == 3'(c)) begin
          if (ch_ctl_q[c][intr_pkg::C_INC_SRC]) begin
            ch_src_q[c] <= ch_src_q[c] + (ch_ctl_q[c][intr_pkg::C_WORD] ? AW'(2) : AW'(1));
          end
          if (ch_ctl_q[c][intr_pkg::C_INC_DST]) begin
            ch_dst_q[c] <= ch_dst_q[c] + (ch_ctl_q[c][intr_pkg::C_WORD] ? AW'(2) : AW'(1));
          end
          if (!ch_ctl_q[c][intr_pkg::C_CONT]) begin
            ch_cnt_q[c] <= ch_cnt_q[c] - CW'(1);
          end
        end
      end
      xfer_q.valid <= xfer_go;
      xfer_q.word  <= ch_ctl_q[xch][intr_pkg::C_WORD];
      xfer_q.ch    <= xch;
      xfer_q.src   <= ch_src_q[xch];
      xfer_q.dst   <= ch_dst_q[xch];
    end
  end

  // ==========================================================================
  // configuration, router history and traps
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      src_sel_q   <= '0;
      svc_map_q   <= '0;
      rtr_edge_q  <= '0;
      rtr_route_q <= '0;
      rtr_pat_q   <= '0;
      rtr_prev_q  <= '0;
      svc_prev_q  <= '0;
      trap_flag_q <= '0;
      trap_pend_q <= '0;
    end else if (ce) begin
      if (wr && paddr == intr_pkg::SRC_SEL) src_sel_q <= pwdata[11:0];
      if (wr && paddr == intr_pkg::PIN_CFG) svc_map_q <= pwdata[2:0];
      if (wr && paddr == intr_pkg::RTR_EDGE) rtr_edge_q <= pwdata[7:0];
      if (wr && paddr == intr_pkg::RTR_ROUTE) rtr_route_q <= pwdata[15:0];
      if (wr && paddr == intr_pkg::RTR_PAT) rtr_pat_q <= pwdata[19:0];
      rtr_prev_q <= rtr_in;
      svc_prev_q <= svc_pin;
      trap_flag_q <= (trap_flag_q & ~((wr && paddr == intr_pkg::TRAP_FLAG) ? pwdata[NT-1:0] : '0))
                   | tev;
      trap_pend_q <= (trap_pend_q & ~(take_trap ? NT'(1) << tidx : '0)) | tev;
    end
  end

  // ==========================================================================
  // service sequencing
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q     <= intr_pkg::ST_IDLE;
      cnt_q       <= '0;
      svc_q       <= '0;
      trap_busy_q <= 1'b0;
      trap_lvl_q  <= '0;
      branch_q    <= '0;
    end else if (ce) begin
      branch_q.valid <= 1'b0;
      if (take_trap) begin
        branch_q <= '{valid: 1'b1, trap: 1'b1, vec: intr_pkg::TRAP_VEC_BASE + 8'(tidx)};
        trap_busy_q <= 1'b1;
        trap_lvl_q  <= tidx;
      end else if (sw_go) begin
        branch_q <= '{valid: 1'b1, trap: 1'b0, vec: sw_trap_num};
      end else if (state_q == intr_pkg::ST_WAIT && cnt_q == '0) begin
        branch_q <= '{valid: 1'b1, trap: 1'b0, vec: intr_pkg::NODE_VEC_BASE + 8'(svc_q)};
      end
      if (trap_done && !take_trap) begin
        trap_busy_q <= 1'b0;
      end
      case (state_q)
        intr_pkg::ST_IDLE: begin
          if (std_go) begin
            state_q <= intr_pkg::ST_WAIT;
            cnt_q   <= resp - 4'h1;
            svc_q   <= best;
          end
        end
        intr_pkg::ST_WAIT: begin
          if (take_trap || cnt_q == '0) begin
            state_q <= intr_pkg::ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: state_q <= intr_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  AST_XFER_ONE: assert property ((ce && xfer_q.valid) |=> !xfer_q.valid)
    else $error("transfer lasted more than one cycle");
  AST_ONE_KIND: assert property (!(xfer_q.valid && branch_q.valid))
    else $error("transfer and branch together");
  AST_RESP_LOAD: assert property ((ce && std_go) |=> cnt_q == $past(resp) - 4'h1)
    else $error("response count wrong");
  AST_RESP_HOLD: assert property ((ce && state_q == intr_pkg::ST_WAIT && cnt_q != '0 && !take_trap)
    |=> !branch_q.valid)
    else $error("branch before response time");
  AST_TRAP_FLAG: assert property ((ce && |tev) |=> (trap_flag_q & $past(tev)) == $past(tev))
    else $error("trap flag not set");
  AST_TRAP_BLOCK: assert property ((ce && trap_busy_q) |=> !xfer_q.valid && state_q != intr_pkg::ST_WAIT)
    else $error("service granted during trap");
  AST_GRANT_PRIO: assert property (grant |-> best_prio > cpu_level && req_q[best] && en_q[best])
    else $error("grant without priority");
  AST_AUTO_CLEAR: assert property ((ce && std_go && !set_evt[best] && !node_we) |=> !req_q[$past(best)])
    else $error("request not cleared");
  AST_CNT_DEC: assert property ((ce && xfer_go && !cont && !ch_we) |=> ch_cnt_q[$past(xch)] == $past(xcnt) - CW'(1))
    else $error("counter not decremented");
  AST_ZERO_STD: assert property ((ce && reach_zero) |=> req_q[$past(best)] && force_std_q[$past(best)])
    else $error("zero count gave no interrupt");
  AST_SW_TRAP: assert property ((ce && sw_go) |=> branch_q.valid && branch_q.vec == $past(sw_trap_num))
    else $error("software trap vector wrong");
endmodule // interrupt_and_event_transfer

/* File: testbench/cpu_model.sv */
// cpu side model: ends each trap service with a one-cycle pulse
`timescale 1ns/1ps
module cpu_model #(
  parameter int SVC = 4
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // branch from the block, release from the bench
  input  wire intr_pkg::branch_s branch,
  input  wire logic              allow,
  // end of trap service
  output logic                   trap_done
);
  // ==========
  // trap service length, stalled while allow is low
  logic       busy_q;
  logic [7:0] cnt_q;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      busy_q    <= 1'b0;
      cnt_q     <= 8'h00;
      trap_done <= 1'b0;
    end else begin
      trap_done <= busy_q && allow && (cnt_q == 8'(SVC));
      if (branch.valid && branch.trap) begin
        busy_q <= 1'b1;
        cnt_q  <= 8'h00;
      end else if (busy_q && allow) begin
        cnt_q <= cnt_q + 8'h01;
        if (cnt_q == 8'(SVC)) begin
          busy_q <= 1'b0;
        end
      end
    end
  end
endmodule // cpu_model

/* File: testbench/interrupt_and_event_transfer_tb.sv */
// testbench for the interrupt and event transfer block
`timescale 1ns/1ps
module interrupt_and_event_transfer_tb;
  // ==========
  // signals
  logic              core_clk, reset, ce, psel, penable, pwrite;
  logic              pready, pslverr, se, ok, jump_cache;
  logic              trap_done, sw_trap_valid, allow;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, q;
  logic [91:0]       periph_req;
  logic [3:0]        shared_src, rtr_in, cpu_level;
  logic [5:0]        hw_trap;
  logic [2:0]        svc_pin;
  logic [7:0]        sw_trap_num;
  intr_pkg::branch_s br;
  intr_pkg::xfer_s   xf;
  int                error_cnt, n_checks, n;

  interrupt_and_event_transfer DUT (
    .core_clk(core_clk), .reset(reset), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_req(periph_req), .shared_src(shared_src), .rtr_in(rtr_in),
    .hw_trap(hw_trap), .svc_pin(svc_pin), .cpu_level(cpu_level),
    .jump_cache(jump_cache), .trap_done(trap_done),
    .sw_trap_valid(sw_trap_valid), .sw_trap_num(sw_trap_num),
    .branch(br), .xfer(xf)
  );
  cpu_model PM (
    .core_clk(core_clk), .reset(reset), .branch(br), .allow(allow),
    .trap_done(trap_done)
  );

  // ==========
  // clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    $display("[ERR] %0t run hang", $time);
    print_verdict;
  end

  // ==========
  // tasks
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge core_clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t >= 20) begin
      error_cnt++;
      $display("[ERR] %0t bus hang", $time);
      print_verdict;
    end
    q = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // waits for a branch (x=0) or a transfer (x=1); ends input pulses
  task automatic wt(input logic x, input int mx);
    ok = 1'b0;
    n = 0;
    while (ok !== 1'b1 && n < mx) begin
      @(posedge core_clk);
      periph_req    <= '0;
      hw_trap       <= '0;
      sw_trap_valid <= 1'b0;
      #1;
      n++;
      ok = (x ? xf.valid : br.valid) === 1'b1;
    end
  endtask

  // ==========
  // scenarios
  initial begin
    reset = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; periph_req = '0; shared_src = '0; rtr_in = '0;
    hw_trap = '0; svc_pin = '0; cpu_level = '0; jump_cache = 1'b1;
    sw_trap_valid = 1'b0; sw_trap_num = '0; allow = 1'b1;
    error_cnt = 0;
    n_checks = 0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    // reset values and an unmapped read
    apb(0, 12'h000, '0);
    ck(q, 32'h0);
    apb(0, intr_pkg::STATUS, '0);
    ck(q[1:0], 32'h1);
    apb(0, 12'h1fc, '0);
    ck({se, q}, {1'b1, 32'h0});
    // software request with both response times
    for (int i = 0; i < 2; i++) begin
      jump_cache <= (i == 0);
      apb(1, 12'h014, 32'hc3);
      wt(0, 30);
      ck({ok, br.trap, br.vec}, 10'h225);
      ck(n >= (i ? 11 : 7) && n <= (i ? 13 : 9), 1);
      apb(0, 12'h014, '0);
      ck(q, 32'h43);
    end
    // priority order and cpu level
    cpu_level <= 4'h6;
    apb(1, 12'h028, 32'h42);
    apb(1, 12'h050, 32'h45);
    @(posedge core_clk);
    periph_req <= (92'h1 << 10) | (92'h1 << 20);
    wt(0, 20);
    ck(ok, 0);
    @(posedge core_clk);
    cpu_level <= 4'h0;
    wt(0, 20);
    ck({ok, br.vec}, 9'h134);
    wt(0, 20);
    ck({ok, br.vec}, 9'h12a);
    // event transfers on channel 2, then the count-zero interrupt
    apb(1, 12'h220, 32'h100);
    apb(1, 12'h224, 32'h200);
    apb(1, 12'h228, 32'h2);
    apb(1, 12'h22c, 32'h7);
    apb(1, 12'h078, 32'h544);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      periph_req <= 92'h1 << 30;
      wt(1, 10);
      ck({ok, xf.word, xf.ch}, 5'h1a);
      ck({xf.src, xf.dst}, {24'h100 + 24'(2 * i), 24'h200 + 24'(2 * i)});
      @(posedge core_clk);
      #1;
      ck(xf.valid, 0);
    end
    wt(0, 30);
    ck({ok, br.vec}, 9'h13e);
    apb(0, 12'h228, '0);
    ck(q, 32'h0);
    apb(0, 12'h220, '0);
    ck(q, 32'h104);
    // hardware trap holds off a standard request
    allow <= 1'b0;
    @(posedge core_clk);
    hw_trap <= 6'h04;
    wt(0, 10);
    ck({ok, br.trap, br.vec}, 10'h302);
    apb(1, 12'h014, 32'hc3);
    wt(0, 20);
    ck(ok, 0);
    apb(0, intr_pkg::TRAP_FLAG, '0);
    ck(q, 32'h4);
    allow <= 1'b1;
    wt(0, 30);
    ck({ok, br.vec}, 9'h125);
    apb(1, intr_pkg::TRAP_FLAG, 32'h4);
    apb(0, intr_pkg::TRAP_FLAG, '0);
    ck(q, 32'h0);
    // service request pin to system request zero
    apb(1, intr_pkg::PIN_CFG, 32'h0);
    @(posedge core_clk);
    svc_pin <= 3'h1;
    wt(0, 10);
    ck({ok, br.trap, br.vec}, 10'h306);
    apb(0, intr_pkg::TRAP_FLAG, '0);
    ck(q, 32'h40);
    apb(1, intr_pkg::TRAP_FLAG, 32'h40);
    // software trap number
    @(posedge core_clk);
    sw_trap_valid <= 1'b1;
    sw_trap_num   <= 8'h55;
    wt(0, 10);
    ck({ok, br.trap, br.vec}, 10'h255);
    // clock enable low drops a software trap pulse
    @(posedge core_clk);
    ce            <= 1'b0;
    sw_trap_valid <= 1'b1;
    wt(0, 10);
    ck(ok, 0);
    @(posedge core_clk);
    ce <= 1'b1;
    // router rising edge into shared node 92
    apb(1, intr_pkg::SRC_SEL, 32'h4);
    apb(1, intr_pkg::RTR_EDGE, 32'h1);
    apb(1, intr_pkg::RTR_ROUTE, 32'h1);
    apb(1, intr_pkg::RTR_PAT, 32'h1);
    apb(1, 12'h170, 32'h41);
    @(posedge core_clk);
    rtr_in <= 4'h1;
    wt(0, 20);
    ck({ok, br.vec}, 9'h17c);
    @(posedge core_clk);
    rtr_in <= 4'h0;
    wt(0, 20);
    ck(ok, 0);
    // falling edge only, pattern miss mode
    apb(1, intr_pkg::RTR_EDGE, 32'h2);
    apb(1, intr_pkg::RTR_PAT, 32'h10001);
    @(posedge core_clk);
    rtr_in <= 4'h1;
    wt(0, 20);
    ck(ok, 0);
    @(posedge core_clk);
    rtr_in <= 4'h0;
    wt(0, 20);
    ck({ok, br.vec}, 9'h17c);
    print_verdict;
  end
endmodule // interrupt_and_event_transfer_tb
